/* File: hdl/fepc_device.sv */
// Flash device end: block / full erase, deep sleep and wake commands.
// Assumes link pins are asynchronous and sampled on clk_sys_i.
// Contract
// - Opcode 52H erases the addressed 32KB block
// - Opcode D8H erases the addressed 64KB block
// - Host sends write permit before any erase
// - Block erase only with exactly 32 bits
// - Block erase cycle starts at select rise
// - Busy flag high during erase; status readable
// - Write permit latch cleared before erase ends
// - Protected block erase is not executed
// - Full erase 60H/C7H needs exactly 8 bits
// - Full erase only when nothing protected
// - Full erase cycle starts with busy set
// - Opcode B9H enters sleep after entry delay
// - Sleep ignores all but ABH and reset pair
// - Sleep command rejected while busy
// - Reset leaves device in standby
// - Other deselects never enter sleep
// - Wake alone then wait wake delay
// - ABH plus three dummies shifts ID out
// - ID repeats until select rises
// - Wake with ID waits same 3000 ns delay as wake alone
// - ABH ignored while busy
`timescale 1ns/1ns
module fepc_device #(
    parameter int unsigned BLOCK_WIPE_CYC = fepc_pkg::BLOCK_WIPE_CYC,
    parameter int unsigned FULL_WIPE_CYC  = fepc_pkg::FULL_WIPE_CYC,
    parameter int unsigned SLEEP_CYC      = fepc_pkg::SLEEP_CYC,
    parameter int unsigned WAKE_CYC       = fepc_pkg::WAKE_CYC,
    parameter int unsigned WAKE_ID_CYC    = fepc_pkg::WAKE_ID_CYC,
    parameter logic [7:0]  DEVICE_ID      = 8'h5a  // Arbitrary value
) (
    input  wire logic                          clk_sys_i,
    input  wire logic                          reset_n_i,
    fepc_link_if.dev                           link,
    input  wire logic [4:0]                    protect_level_bits_i,
    input  wire logic                          protect_complement_bit_i,
    output logic                               busy_flag_o,
    output logic                               write_permit_latch_o,
    output logic                               sleeping_o,
    output logic                               wipe_start_o,
    output logic                               wipe_full_o,
    output logic [fepc_pkg::ADDR_W-1:0]        wipe_addr_o,
    output logic                               wipe_done_o
);
    import fepc_pkg::*;

    if (BLOCK_WIPE_CYC < 1 || FULL_WIPE_CYC < 1 || SLEEP_CYC < 1 || WAKE_CYC < 1 || WAKE_ID_CYC < 1)
    begin : g_chk
        $error("fepc_device: timing counts must be at least one cycle");
    end

    typedef struct packed {
        logic             cs_m;
        logic             cs_s;
        logic             cs_q;
        logic             sck_m;
        logic             sck_s;
        logic             sck_q;
        logic             si_m;
        logic             si_s;
        logic [5:0]       cnt;
        logic [7:0]       shreg;
        logic [7:0]       opcode;
        logic [23:0]      addr;
        logic [2:0]       out_idx;
        logic             so_d;
        logic             so_oe;
        logic             wpl;
        logic             rst_armed;
        logic [31:0]      busy_cnt;
        fepc_pwr_t        pwr;
        logic [31:0]      ptmr;
        logic             wipe_start;
        logic             wipe_full;
        logic             wipe_done;
        logic [23:0]      wipe_addr;
    } fepc_dev_state_t;

    fepc_dev_state_t r;
    fepc_dev_state_t n;

    logic       busy;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_rise;
    logic       blk_prot;
    logic       full_ok;
    logic [7:0] status_byte;
    logic [7:0] src_byte;
    logic       out_phase;

    ////////////////////////////////////////////////////////////////////////
    // Protection decode
    function automatic logic fepc_prot(input logic [4:0] bp, input logic cmp, input logic [5:0] blk);
        logic [6:0] n_blk;
        logic       hit;
        n_blk = 7'h00;
        hit   = 1'b0;
        if (bp[2:0] != 3'h0)
        begin
            n_blk = 7'h01 << (bp[2:0] - 3'h1);
            hit   = bp[3] ? ({1'b0, blk} < n_blk) : ({1'b0, blk} >= (FULL_BLOCKS - n_blk));
        end
        return hit ^ cmp;
    endfunction : fepc_prot

    assign busy        = (r.busy_cnt != 32'h0);
    assign sck_rise    = r.sck_s & ~r.sck_q;
    assign sck_fall    = ~r.sck_s & r.sck_q;
    assign cs_rise     = r.cs_s & ~r.cs_q;
    assign blk_prot    = fepc_prot(protect_level_bits_i, protect_complement_bit_i,
                                   r.addr[BLK_MSB:BLK_LSB]);
    assign full_ok     = ((protect_level_bits_i[2:0] == 3'h0) && !protect_complement_bit_i) ||
                         ((protect_level_bits_i[2:0] == LEVEL_ALL) && protect_complement_bit_i);
    assign status_byte = {protect_complement_bit_i, protect_level_bits_i, r.wpl, busy};
    assign src_byte    = (r.opcode == OP_STATUS) ? status_byte : DEVICE_ID;
    // ID only once three dummy bytes passed and no cycle runs
    assign out_phase   = ((r.opcode == OP_WAKE_ID) && (r.cnt >= CNT_ADDR) && !busy &&
                          (r.pwr == P_ACTIVE || r.pwr == P_SLEEP)) ||
                         ((r.opcode == OP_STATUS) && (r.cnt >= CNT_OP) && (r.pwr == P_ACTIVE));

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        n            = r;
        n.wipe_start = 1'b0;
        n.wipe_done  = 1'b0;
        n.cs_m       = link.cs_n;
        n.cs_s       = r.cs_m;
        n.cs_q       = r.cs_s;
        n.sck_m      = link.sclk;
        n.sck_s      = r.sck_m;
        n.sck_q      = r.sck_s;
        n.si_m       = link.si;
        n.si_s       = r.si_m;

        // Self-timed erase
        if (busy)
        begin
            n.busy_cnt = r.busy_cnt - 32'h1;
            if (r.busy_cnt == 32'h1)
            begin
                n.wipe_done = 1'b1;
            end
        end

        // Power transitions
        if (r.pwr == P_ENTER || r.pwr == P_WAKE)
        begin
            if (r.ptmr <= 32'h1)
            begin
                n.ptmr = 32'h0;
                n.pwr  = (r.pwr == P_ENTER) ? P_SLEEP : P_ACTIVE;
            end
            else
            begin
                n.ptmr = r.ptmr - 32'h1;
            end
        end

        // Shift in / out while selected
        if (r.cs_s)
        begin
            n.cnt     = 6'h00;
            n.out_idx = 3'h0;
            n.so_oe   = 1'b0;
        end
        else
        begin
            if (sck_rise)
            begin
                n.shreg = {r.shreg[6:0], r.si_s};
                if (r.cnt != CNT_MAX)
                begin
                    n.cnt = r.cnt + 6'h01;
                end
                if (r.cnt == CNT_OP - 6'h01)
                begin
                    n.opcode = {r.shreg[6:0], r.si_s};
                end
                if (r.cnt >= CNT_OP && r.cnt < CNT_ADDR)
                begin
                    n.addr = {r.addr[22:0], r.si_s};
                end
            end
            if (sck_fall && out_phase)
            begin
                n.so_d    = src_byte[3'h7 - r.out_idx];
                n.so_oe   = 1'b1;
                n.out_idx = r.out_idx + 3'h1;
            end
        end

        // Frame end: decode on select rise
        if (cs_rise && r.cnt >= CNT_OP)
        begin
            n.rst_armed = 1'b0;
            if (r.pwr == P_ACTIVE && !busy)
            begin
                case (r.opcode)
                    OP_WRITE_PERMIT:
                    begin
                        if (r.cnt == CNT_OP)
                        begin
                            n.wpl = 1'b1;
                        end
                    end
                    OP_WIPE32, OP_WIPE64:
                    begin
                        if (r.cnt == CNT_ADDR && r.wpl && !blk_prot)
                        begin
                            n.busy_cnt   = BLOCK_WIPE_CYC;
                            n.wpl        = 1'b0;
                            n.wipe_start = 1'b1;
                            n.wipe_full  = 1'b0;
                            n.wipe_addr  = r.addr & ((r.opcode == OP_WIPE64) ? WIPE64_MASK : WIPE32_MASK);
                        end
                    end
                    OP_FULL_A, OP_FULL_B:
                    begin
                        if (r.cnt == CNT_OP && r.wpl && full_ok)
                        begin
                            n.busy_cnt   = FULL_WIPE_CYC;
                            n.wpl        = 1'b0;
                            n.wipe_start = 1'b1;
                            n.wipe_full  = 1'b1;
                            n.wipe_addr  = 24'h000000;
                        end
                    end
                    OP_SLEEP:
                    begin
                        if (r.cnt == CNT_OP)
                        begin
                            n.pwr  = P_ENTER;
                            n.ptmr = SLEEP_CYC;
                        end
                    end
                    OP_RST_EN:
                    begin
                        n.rst_armed = (r.cnt == CNT_OP);
                    end
                    OP_RST:
                    begin
                        if (r.cnt == CNT_OP && r.rst_armed)
                        begin
                            n.wpl = 1'b0;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (r.pwr == P_SLEEP)
            begin
                case (r.opcode)
                    OP_WAKE_ID:
                    begin
                        if (r.cnt == CNT_OP)
                        begin
                            n.pwr  = P_WAKE;
                            n.ptmr = WAKE_CYC;
                        end
                        else if (r.cnt >= CNT_ADDR)
                        begin
                            n.pwr  = P_WAKE;
                            n.ptmr = WAKE_ID_CYC;
                        end
                    end
                    OP_RST_EN:
                    begin
                        n.rst_armed = (r.cnt == CNT_OP);
                    end
                    OP_RST:
                    begin
                        if (r.cnt == CNT_OP && r.rst_armed)
                        begin
                            n.pwr = P_ACTIVE;
                            n.wpl = 1'b0;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset gives standby
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            r       <= '0;
            r.cs_m  <= 1'b1;
            r.cs_s  <= 1'b1;
            r.cs_q  <= 1'b1;
            r.pwr   <= P_ACTIVE;
        end
        else
        begin
            r <= n;
        end
    end

    assign link.so_d           = r.so_d;
    assign link.so_oe          = r.so_oe;
    assign busy_flag_o         = busy;
    assign write_permit_latch_o = r.wpl;
    assign sleeping_o          = (r.pwr == P_SLEEP);
    assign wipe_start_o        = r.wipe_start;
    assign wipe_full_o         = r.wipe_full;
    assign wipe_addr_o         = r.wipe_addr;
    assign wipe_done_o         = r.wipe_done;

endmodule : fepc_device

/* File: hdl/fepc_pkg.sv */
// Shared constants for the erase / power-down command block.
// Assumes a single-line serial link and a 20 MHz system clock.
package fepc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;

    // Opcodes
    localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OP_STATUS       = 8'h05;
    localparam logic [7:0] OP_WIPE32       = 8'h52;
    localparam logic [7:0] OP_WIPE64       = 8'hd8;
    localparam logic [7:0] OP_FULL_A       = 8'h60;
    localparam logic [7:0] OP_FULL_B       = 8'hc7;
    localparam logic [7:0] OP_SLEEP        = 8'hb9;
    localparam logic [7:0] OP_WAKE_ID      = 8'hab;
    localparam logic [7:0] OP_RST_EN       = 8'h66;
    localparam logic [7:0] OP_RST          = 8'h99;

    // Frame bit counts
    localparam logic [5:0] CNT_OP   = 6'h08;
    localparam logic [5:0] CNT_ADDR = 6'h20;
    localparam logic [5:0] CNT_MAX  = 6'h28;

    // Address layout
    localparam int unsigned ADDR_W      = 24;
    localparam logic [23:0] WIPE32_MASK = 24'hff8000;
    localparam logic [23:0] WIPE64_MASK = 24'hff0000;
    localparam int unsigned BLK_LSB     = 16;
    localparam int unsigned BLK_MSB     = 21;
    localparam logic [6:0]  FULL_BLOCKS = 7'h40;
    localparam logic [2:0]  LEVEL_ALL   = 3'h7;

    // Times in ns, then cycles (rounded up)
    localparam int unsigned BLOCK_WIPE_TIME_NS   = 200000;
    localparam int unsigned FULL_WIPE_TIME_NS    = 2000000;
    localparam int unsigned SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int unsigned WAKE_DELAY_NS        = 3000;
    localparam int unsigned WAKE_WITH_ID_NS      = 3000;
    localparam int unsigned BLOCK_WIPE_CYC = (BLOCK_WIPE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FULL_WIPE_CYC  = (FULL_WIPE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLEEP_CYC      = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CYC       = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_ID_CYC    = (WAKE_WITH_ID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host link timing
    localparam int unsigned HOST_HALF_CYC = 8;
    localparam int unsigned HOST_GAP_CYC  = 4;

    typedef enum logic [1:0] {
        P_ACTIVE,
        P_ENTER,
        P_SLEEP,
        P_WAKE
    } fepc_pwr_t;

    typedef enum logic [1:0] {
        H_IDLE,
        H_LOW,
        H_HIGH,
        H_GAP
    } fepc_hstate_t;

endpackage : fepc_pkg

/* File: hdl/fepc_link_if.sv */
// Serial link between the flash controller and the flash device.
// Assumes the bench resolves the shared data-out wire from so_oe.
`timescale 1ns/1ns
interface fepc_link_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so_d;
    logic so_oe;

    modport dev  (input cs_n, input sclk, input si, output so_d, output so_oe);
    modport host (output cs_n, output sclk, output si, input so_d, input so_oe);
endinterface : fepc_link_if

/* File: hdl/fepc_host.sv */
// Flash controller end: frames one command per request on the link, with a write permit frame first for each erase.
// Assumes the device answers on so_d after falling serial clock edges.
`timescale 1ns/1ns
module fepc_host #(
    parameter int unsigned HALF_CYC    = fepc_pkg::HOST_HALF_CYC,
    parameter int unsigned GAP_CYC     = fepc_pkg::HOST_GAP_CYC,
    parameter int unsigned WAKE_CYC    = fepc_pkg::WAKE_CYC,
    parameter int unsigned WAKE_ID_CYC = fepc_pkg::WAKE_ID_CYC
) (
    input  wire logic                          clk_sys_i,
    input  wire logic                          reset_n_i,
    fepc_link_if.host                          link,
    input  wire logic                          cmd_valid_i,
    output logic                               cmd_ready_o,
    input  wire logic [7:0]                    cmd_op_i,
    input  wire logic [fepc_pkg::ADDR_W-1:0]   cmd_addr_i,
    input  wire logic                          cmd_has_addr_i,
    input  wire logic [3:0]                    cmd_rd_bytes_i,
    output logic                               rsp_valid_o,
    output logic [7:0]                         rsp_data_o
);
    import fepc_pkg::*;

    if (HALF_CYC < 2 || HALF_CYC > 255 || GAP_CYC < 1 || WAKE_CYC < 1 || WAKE_ID_CYC < 1)
    begin : g_chk
        $error("fepc_host: bad timing parameters");
    end

    typedef struct packed {
        fepc_hstate_t st;
        logic         pre;
        logic [7:0]   op;
        logic [23:0]  addr;
        logic         has_addr;
        logic [3:0]   rd;
        logic [31:0]  tx;
        logic [7:0]   bitn;
        logic [7:0]   total;
        logic [7:0]   hdr;
        logic [7:0]   div;
        logic [31:0]  gap;
        logic [7:0]   rx;
        logic [2:0]   rcnt;
        logic         cs_n;
        logic         sclk;
        logic         mosi;
        logic         rsp_valid;
        logic [7:0]   rsp_data;
        logic         so_m;
        logic         so_s;
    } fepc_host_state_t;

    fepc_host_state_t r;
    fepc_host_state_t n;

    logic is_erase;

    assign is_erase = (cmd_op_i == OP_WIPE32) || (cmd_op_i == OP_WIPE64) ||
                      (cmd_op_i == OP_FULL_A) || (cmd_op_i == OP_FULL_B);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic       f_go;
        logic [7:0] f_op;
        logic       f_has;
        logic [3:0] f_rd;
        f_go  = 1'b0;
        f_op  = r.op;
        f_has = r.has_addr;
        f_rd  = r.rd;

        n           = r;
        n.rsp_valid = 1'b0;
        n.so_m      = link.so_d;
        n.so_s      = r.so_m;

        case (r.st)
            H_IDLE:
            begin
                if (cmd_valid_i)
                begin
                    n.op       = cmd_op_i;
                    n.addr     = cmd_addr_i;
                    n.has_addr = cmd_has_addr_i;
                    n.rd       = cmd_rd_bytes_i;
                    f_go       = 1'b1;
                    f_op       = is_erase ? OP_WRITE_PERMIT : cmd_op_i;
                    f_has      = is_erase ? 1'b0 : cmd_has_addr_i;
                    f_rd       = is_erase ? 4'h0 : cmd_rd_bytes_i;
                    n.pre      = is_erase;
                end
            end
            H_LOW:
            begin
                if (r.div == 8'h00)
                begin
                    n.sclk = 1'b1;
                    n.div  = 8'(HALF_CYC - 1);
                    n.st   = H_HIGH;
                end
                else
                begin
                    n.div = r.div - 8'h01;
                end
            end
            H_HIGH:
            begin
                if (r.div == 8'h00)
                begin
                    n.rx = {r.rx[6:0], r.so_s};
                    if (r.bitn >= r.hdr)
                    begin
                        n.rcnt = r.rcnt + 3'h1;
                        if (r.rcnt == 3'h7)
                        begin
                            n.rsp_valid = 1'b1;
                            n.rsp_data  = {r.rx[6:0], r.so_s};
                        end
                    end
                    n.sclk = 1'b0;
                    if (r.bitn == r.total - 8'h01)
                    begin
                        n.cs_n = 1'b1;
                        n.mosi = 1'b0;
                        n.st   = H_GAP;
                        if (r.op == OP_WAKE_ID && !r.pre)
                        begin
                            n.gap = (r.rd != 4'h0) ? 32'(WAKE_ID_CYC) : 32'(WAKE_CYC);
                        end
                        else
                        begin
                            n.gap = 32'(GAP_CYC);
                        end
                    end
                    else
                    begin
                        n.bitn = r.bitn + 8'h01;
                        n.tx   = {r.tx[30:0], 1'b0};
                        n.mosi = r.tx[30];
                        n.div  = 8'(HALF_CYC - 1);
                        n.st   = H_LOW;
                    end
                end
                else
                begin
                    n.div = r.div - 8'h01;
                end
            end
            H_GAP:
            begin
                if (r.gap <= 32'h1)
                begin
                    n.st = H_IDLE;
                    if (r.pre)
                    begin
                        f_go  = 1'b1;
                        n.pre = 1'b0;
                    end
                end
                else
                begin
                    n.gap = r.gap - 32'h1;
                end
            end
            default:
            begin
                n.st = H_IDLE;
            end
        endcase

        // Frame launch
        if (f_go)
        begin
            n.tx    = {f_op, (f_go && r.st == H_IDLE) ? cmd_addr_i : r.addr};
            n.hdr   = f_has ? 8'h20 : 8'h08;
            n.total = (f_has ? 8'h20 : 8'h08) + {1'b0, f_rd, 3'h0};
            n.bitn  = 8'h00;
            n.rcnt  = 3'h0;
            n.cs_n  = 1'b0;
            n.sclk  = 1'b0;
            n.mosi  = f_op[7];
            n.div   = 8'(HALF_CYC - 1);
            n.st    = H_LOW;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            r      <= '0;
            r.cs_n <= 1'b1;
            r.st   <= H_IDLE;
        end
        else
        begin
            r <= n;
        end
    end

    assign link.cs_n   = r.cs_n;
    assign link.sclk   = r.sclk;
    assign link.si     = r.mosi;
    assign cmd_ready_o = (r.st == H_IDLE) && !r.pre;
    assign rsp_valid_o = r.rsp_valid;
    assign rsp_data_o  = r.rsp_data;

endmodule : fepc_host

/* File: test/fepc_link_properties.sv */
// Link and status properties of the erase and sleep block.
// Assumes it sits beside the link interface in the bench.
`timescale 1ns/1ns
module fepc_link_properties (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so_oe,
    input wire logic busy_flag_o,
    input wire logic write_permit_latch_o,
    input wire logic sleeping_o,
    input wire logic wipe_start_o,
    input wire logic wipe_done_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    sequence busy_run;
        busy_flag_o [*8];
    endsequence
    sclk_idle_a: assert property (cs_n |-> !sclk) else $error("sclk moves unselected");
    si_hold_a: assert property (sclk && $past(sclk) |-> $stable(si)) else $error("si moved");
    oe_drop_a: assert property ($rose(cs_n) |-> ##[0:6] !so_oe) else $error("so held");
    start_cs_a: assert property (wipe_start_o |-> cs_n) else $error("start while selected");
    start_busy_a: assert property (wipe_start_o |-> ##[0:1] busy_run) else $error("busy short");
    latch_clear_a: assert property (wipe_start_o |-> ##[0:1] !write_permit_latch_o) else $error("latch");
    done_idle_a: assert property (wipe_done_o |-> ##[0:1] !busy_flag_o) else $error("busy stuck");
    busy_awake_a: assert property (busy_flag_o |-> !sleeping_o) else $error("sleep while busy");
    sleep_cs_a: assert property ($rose(sleeping_o) |-> cs_n) else $error("sleep selected");
endmodule : fepc_link_properties

/* File: test/flash_erase_powerdown_cmds_tb_top.sv */
// Bench joining controller and device over the serial link.
// Assumes design sources and checker are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end
module flash_erase_powerdown_cmds_tb_top;
    import fepc_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        vld = 1'b0, has = 1'b0, cmp = 1'b0, rdy, rv, busy, wpl, slp, ws, wf, wd;
    logic [7:0]  op = 8'h00, rdat;
    logic [23:0] adr = 24'h000000, wa;
    logic [3:0]  nrd = 4'h0;
    logic [4:0]  bp = 5'h00;
    int          miscompares = 0, samples_checked = 0, starts = 0, reads = 0, n = 0;
    fepc_link_if u_fepc_link_if ();
    // Device id value is arbitrary
    fepc_device #(.BLOCK_WIPE_CYC(600), .FULL_WIPE_CYC(60), .WAKE_CYC(10), .WAKE_ID_CYC(10),
        .DEVICE_ID(8'h3c)) u_fepc_device (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(u_fepc_link_if.dev),
        .protect_level_bits_i(bp), .protect_complement_bit_i(cmp), .busy_flag_o(busy), .write_permit_latch_o(wpl),
        .sleeping_o(slp), .wipe_start_o(ws), .wipe_full_o(wf), .wipe_addr_o(wa), .wipe_done_o(wd));
    fepc_host u_fepc_host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .link(u_fepc_link_if.host), .cmd_valid_i(vld), .cmd_ready_o(rdy), .cmd_op_i(op), .cmd_addr_i(adr),
        .cmd_has_addr_i(has), .cmd_rd_bytes_i(nrd), .rsp_valid_o(rv), .rsp_data_o(rdat));
    fepc_link_properties u_fepc_link_properties (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .cs_n(u_fepc_link_if.cs_n), .sclk(u_fepc_link_if.sclk), .si(u_fepc_link_if.si), .so_oe(u_fepc_link_if.so_oe),
        .busy_flag_o(busy), .write_permit_latch_o(wpl), .sleeping_o(slp), .wipe_start_o(ws), .wipe_done_o(wd));
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        starts <= starts + int'(ws);
        reads <= reads + int'(rv);
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic cmd(input logic [7:0] o, input logic [23:0] a, input logic h, input logic [3:0] r);
        int i;
        i = 0;
        while (busy !== 1'b0 && (o == OP_WIPE32 || o == OP_WIPE64 || o == OP_FULL_A || o == OP_FULL_B) && i < 3000)
        begin
            @(posedge clk_sys_i);
            #2 i++;
        end
        op = o;
        adr = a;
        has = h;
        nrd = r;
        vld = 1'b1;
        @(posedge clk_sys_i);
        #2 vld = 1'b0;
        while (rdy !== 1'b1 && i < 3000)
        begin
            @(posedge clk_sys_i);
            #2 i++;
        end
        if (i >= 3000)
        begin
            miscompares++;
            end_sim;
        end
        repeat (8) @(posedge clk_sys_i);
        #2;
    endtask : cmd
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        #2 reset_n_i = 1'b1;
        cmd(OP_WIPE32, 24'h129abc, 1'b1, 4'h0);
        `CHK({wa, busy, wpl, wf}, {24'h128000, 3'b100})
        cmd(OP_STATUS, 24'h000000, 1'b0, 4'h1);
        `CHK(rdat, 8'h01)
        cmd(OP_WIPE64, 24'h129abc, 1'b1, 4'h0);
        `CHK(wa, 24'h120000)
        cmd(OP_SLEEP, 24'h000000, 1'b0, 4'h0);
        repeat (64) @(posedge clk_sys_i);
        #2 `CHK({busy, slp}, 2'b10)
        $display("block erase test done");
        for (int k = 0; k < 2; k++)
        begin
            bp = k ? 5'h07 : 5'h00;
            cmp = k[0];
            cmd(k ? OP_FULL_B : OP_FULL_A, 24'h000000, 1'b0, 4'h0);
            `CHK({wa, wf, busy}, {24'h000000, 2'b11})
        end
        bp = 5'h01;
        cmp = 1'b0;
        n = starts;
        cmd(OP_WIPE32, 24'h3f1234, 1'b1, 4'h0);
        cmd(OP_FULL_A, 24'h000000, 1'b0, 4'h0);
        bp = 5'h00;
        cmd(OP_WIPE64, 24'h000000, 1'b0, 4'h0);
        cmd(OP_FULL_B, 24'h000000, 1'b1, 4'h0);
        `CHK(starts, n)
        $display("full erase and refusal test done");
        for (int k = 0; k < 2; k++)
        begin
            cmd(OP_SLEEP, 24'h000000, 1'b0, 4'h0);
            repeat (64) @(posedge clk_sys_i);
            #2 `CHK(slp, 1'b1)
            cmd(OP_WIPE64, 24'h000000, 1'b1, 4'h0);
            `CHK({starts == n, slp}, 2'b11)
            n = reads;
            cmd(OP_WAKE_ID, 24'h000000, k[0], k ? 4'h2 : 4'h0);
            `CHK({slp, reads - n}, {1'b0, k * 2})
            if (k)
                `CHK(rdat, 8'h3c)
            n = starts;
        end
        $display("sleep and wake test done");
        end_sim;
    end
    initial
    begin
        #3000000;
        miscompares++;
        end_sim;
    end
endmodule : flash_erase_powerdown_cmds_tb_top
